// *** logic/spi_engine.sv ***
// serial peripheral engine, host or client, normal or buffered
// assumes Avalon-MM master on clk and asynchronous serial pins
// Operation
// - host normal early data write sets write collision
// - normal mode: received byte to buffer, overwritten
// - done flag plus enable raises interrupt
// - buffered enable bit; wait bit ignored as host
// - host buffered: first write sends, next holds
// - buffered: two-entry receive fifo, read pops
// - all-sent flag when shifter and holding empty
// - host select low: drop host, set done
// - select ignored if ignore bit or output
// - client idle while deselected, loads allowed
// - client normal: done flag per byte
// - client normal busy write dropped, collision
// - deselect halts shifting, drops partial byte
// - client wait-off: writes buffered, dummy first
// - write with holding full is dropped
// - holding write clears empty; copy sets it
// - receive flag then all-sent, cycle apart
// - client wait-on: user data sent immediately
// - host data write starts a transfer
// - deselect resets client shifting state
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "spi_params.svh"
module spi_engine (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] address,
    input wire logic read,
    input wire logic write,
    input wire spi_pkg::word_t writedata,
    output spi_pkg::word_t readdata,
    output logic waitrequest,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    input wire logic ss_n_in,
    output logic irq
);
    import spi_pkg::*;

    function automatic logic flag_upd(input logic cur, input logic set,
                                      input logic clr);
        flag_upd = set | (cur & ~clr);
    endfunction

    spi_shift_if sh ();
    spi_shifter u_shifter (.clk(clk), .rst_n(rst_n), .port(sh));

    logic [3:0] pins_s;
    spi_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({ss_n_in, miso_in, mosi_in, sck_in}),
        .q(pins_s)
    );
    wire sck_s = pins_s[0];
    wire mosi_s = pins_s[1];
    wire miso_s = pins_s[2];
    wire ss_n_s = pins_s[3];

    // bus slave: every access waits exactly one cycle
    logic resp_r;
    word_t readdata_r;
    logic pop_ok_r;
    assign waitrequest = (read | write) & ~resp_r;
    assign readdata = readdata_r;
    wire wr_go = write & resp_r;
    wire rd_go = read & resp_r;
    wire rd_cap = read & ~resp_r;

    byte_t ctl1_r, ctl2_r, ien_r;
    wire wr_ctl1 = wr_go & (address == `SPI_IDX_CTL1);
    wire wr_ctl2 = wr_go & (address == `SPI_IDX_CTL2);
    wire wr_ien = wr_go & (address == `SPI_IDX_IEN);
    wire wr_flag = wr_go & (address == `SPI_IDX_FLAG);
    wire [7:0] clr = wr_flag ? writedata[7:0] : 8'h00;

    wire en = ctl1_r[`SPI_B_ENABLE];
    wire buffered_mode_enable = ctl2_r[`SPI_B_BUFFERED_MODE_ENABLE];
    wire is_host = en & ctl1_r[`SPI_B_HOST];
    wire is_client = en & ~ctl1_r[`SPI_B_HOST];
    wire ss_low = ~ss_n_s;
    // the wait bit only matters for a client
    wire waitrx = ctl2_r[`SPI_B_WAITRX] & is_client;
    // host loses mastery only when select is an unignored input
    wire ss_lost = is_host & ~ctl2_r[`SPI_B_SSIGN]
                   & ~ctl2_r[`SPI_B_SSOUT] & ss_low;

    // client clock edges from the synchronised pin
    logic sck_prev_r;
    wire sel = is_client & ss_low;
    wire sck_rise = sel & sck_s & ~sck_prev_r;
    wire sck_fall = sel & ~sck_s & sck_prev_r;

    // host serial clock generator
    host_st_e st_r;
    logic [2:0] half_r;
    wire half_end = (half_r == 3'(`SPI_SCK_HALF_CYC - 1));
    wire host_smp = (st_r == ST_LOW) & half_end;
    wire host_sft = (st_r == ST_HIGH) & half_end;

    assign sh.sample = is_host ? host_smp : sck_rise;
    assign sh.shift = is_host ? host_sft : sck_fall;
    assign sh.in_bit = is_host ? miso_s : mosi_s;
    // deselect or loss of mastery clears the bit count
    assign sh.abort = ~en | ss_lost | (is_client & ss_n_s);

    // buffered transmit path state
    byte_t tx_buf_r;
    logic tx_full_r;
    logic dre_r;
    logic shl_r;
    logic done_d1_r, done_d2_r;

    wire busy_x = is_host ? ((st_r != ST_IDLE) | sh.done) : ~sh.cnt_zero;
    wire wr_data = wr_go & (address == `SPI_IDX_DATA) & en;
    wire wr_coll = wr_data & ~buffered_mode_enable & busy_x;
    wire wr_norm = wr_data & ~buffered_mode_enable & ~busy_x;
    // straight to the shifter when idle; a wait-off client never
    wire can_direct = ~busy_x & ~shl_r & ~sh.done & (is_host | waitrx);
    wire wr_direct = wr_data & buffered_mode_enable & dre_r & can_direct;
    wire wr_buf = wr_data & buffered_mode_enable & dre_r & ~can_direct;
    wire copy = buffered_mode_enable & sh.done & tx_full_r;
    assign sh.load = wr_norm | wr_direct | copy;
    assign sh.load_data = copy ? tx_buf_r : writedata[7:0];
    wire host_start = sh.load & is_host;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_IDLE;
            half_r <= 3'h0;
        end else if (sh.abort | ~is_host) begin
            st_r <= ST_IDLE;
            half_r <= 3'h0;
        end else begin
            half_r <= (half_end | (st_r == ST_IDLE)) ? 3'h0 : half_r + 3'h1;
            unique case (st_r)
                ST_IDLE: if (host_start) st_r <= ST_LOW;
                ST_LOW: if (half_end) st_r <= ST_HIGH;
                ST_HIGH: if (half_end)
                    st_r <= sh.cnt_last ? ST_IDLE : ST_LOW;
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // register writes; host bit falls on loss of mastery
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl1_r <= `SPI_RST_CTL;
            ctl2_r <= `SPI_RST_CTL;
            ien_r <= `SPI_RST_CTL;
        end else begin
            if (ss_lost)
                ctl1_r[`SPI_B_HOST] <= 1'b0;
            else if (wr_ctl1)
                ctl1_r <= writedata[7:0] & `SPI_CTL1_MASK;
            if (wr_ctl2)
                ctl2_r <= writedata[7:0] & `SPI_CTL2_MASK;
            if (wr_ien)
                ien_r <= writedata[7:0] & `SPI_IEN_MASK;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_buf_r <= `SPI_RST_BYTE;
            tx_full_r <= 1'b0;
            dre_r <= 1'b1;
            shl_r <= 1'b0;
        end else if (~en) begin
            tx_full_r <= 1'b0;
            dre_r <= 1'b1;
            shl_r <= 1'b0;
        end else begin
            if (wr_buf)
                tx_buf_r <= writedata[7:0];
            tx_full_r <= wr_buf | (tx_full_r & ~copy);
            dre_r <= copy | (dre_r & ~wr_buf);
            shl_r <= sh.load | (shl_r & ~sh.done);
        end
    end

    // normal mode receive and flags
    byte_t rx_data_r;
    logic if_r, write_collision_flag_r, rxc_r, txc_r, ovf_r;
    wire done_n = sh.done & ~buffered_mode_enable;

    // receive fifo, two entries, head index plus count
    byte_t fifo_r [0:1];
    logic head_r;
    logic [1:0] fcnt_r;
    wire push = buffered_mode_enable & sh.done;
    wire pop = rd_go & pop_ok_r;
    wire push_ok = push & ((fcnt_r != 2'h2) | pop);
    wire wr_idx = head_r ^ fcnt_r[0];
    wire [1:0] fcnt_nxt = fcnt_r + {1'b0, push_ok} - {1'b0, pop};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fifo_r[0] <= `SPI_RST_BYTE;
            fifo_r[1] <= `SPI_RST_BYTE;
            head_r <= 1'b0;
            fcnt_r <= 2'h0;
        end else begin
            if (push_ok)
                fifo_r[wr_idx] <= sh.rx_byte;
            if (pop)
                head_r <= ~head_r;
            fcnt_r <= fcnt_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_data_r <= `SPI_RST_BYTE;
            if_r <= 1'b0;
            write_collision_flag_r <= 1'b0;
            rxc_r <= 1'b0;
            txc_r <= 1'b0;
            ovf_r <= 1'b0;
            done_d1_r <= 1'b0;
            done_d2_r <= 1'b0;
        end else begin
            if (done_n)
                rx_data_r <= sh.rx_byte;
            if_r <= flag_upd(if_r, done_n | ss_lost, clr[`SPI_B_IF]);
            write_collision_flag_r <= flag_upd(write_collision_flag_r, wr_coll, clr[`SPI_B_WRITE_COLLISION_FLAG]);
            done_d1_r <= push;
            done_d2_r <= done_d1_r;
            rxc_r <= flag_upd(rxc_r, done_d1_r, clr[`SPI_B_RXC]);
            txc_r <= flag_upd(txc_r, done_d2_r & ~shl_r & ~tx_full_r,
                              clr[`SPI_B_TXC]);
            ovf_r <= flag_upd(ovf_r, push & ~push_ok, clr[`SPI_B_OVF]);
        end
    end

    // read mux, captured in the waiting cycle
    wire [7:0] flags_n = {if_r, write_collision_flag_r, 6'h00};
    wire [7:0] flags_b = {rxc_r, txc_r, dre_r, 4'h0, ovf_r};
    wire fifo_any = (fcnt_r != 2'h0);
    wire [7:0] data_rd = buffered_mode_enable ? (fifo_any ? fifo_r[head_r] : 8'h00)
                               : rx_data_r;
    logic [7:0] rd_mux;
    always_comb begin
        unique case (address)
            `SPI_IDX_CTL1: rd_mux = ctl1_r;
            `SPI_IDX_CTL2: rd_mux = ctl2_r;
            `SPI_IDX_IEN: rd_mux = ien_r;
            `SPI_IDX_FLAG: rd_mux = buffered_mode_enable ? flags_b : flags_n;
            `SPI_IDX_DATA: rd_mux = data_rd;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resp_r <= 1'b0;
            readdata_r <= 32'h0000_0000;
            pop_ok_r <= 1'b0;
        end else begin
            resp_r <= (read | write) & ~resp_r;
            if (rd_cap)
                readdata_r <= {24'h00_0000, rd_mux};
            pop_ok_r <= rd_cap & buffered_mode_enable & fifo_any
                        & (address == `SPI_IDX_DATA);
        end
    end

    // pin drive; miso only while selected as a client
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // matches the synchroniser's reset level, so no false edge
            sck_prev_r <= 1'b1;
            sck_out <= 1'b0;
        end else begin
            sck_prev_r <= sck_s;
            sck_out <= (st_r == ST_HIGH) & ~(host_sft);
        end
    end
    assign sck_oe = is_host;
    assign mosi_out = sh.out_bit;
    assign mosi_oe = is_host;
    assign miso_out = sh.out_bit;
    assign miso_oe = sel;

    // interrupts are level while flag and enable are both set
    assign irq = buffered_mode_enable
        ? ((rxc_r & ien_r[`SPI_B_RXCIE]) | (txc_r & ien_r[`SPI_B_ALL_SENT_IRQ_ENABLE])
           | (dre_r & ien_r[`SPI_B_DREIE]))
        : (if_r & ien_r[`SPI_B_IE]);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_copy;
        buffered_mode_enable & sh.done & tx_full_r & en;
    endsequence
    sequence s_flag_walk;
        ##1 dre_r ##1 rxc_r;
    endsequence

    chk_collision_flag: assert property (
        wr_coll |=> write_collision_flag_r)
        else $error("collision write did not set collision flag");
    chk_done_flag: assert property (
        done_n |=> if_r)
        else $error("finished byte did not set done flag");
    chk_rx_capture: assert property (
        done_n |=> rx_data_r == $past(sh.rx_byte))
        else $error("received byte not captured");
    chk_select_loss: assert property (
        ss_lost |=> !ctl1_r[`SPI_B_HOST] && if_r)
        else $error("select loss did not demote host");
    chk_select_ignored: assert property (
        is_host && (ctl2_r[`SPI_B_SSIGN] || ctl2_r[`SPI_B_SSOUT])
        && !wr_ctl1 |=> ctl1_r[`SPI_B_HOST])
        else $error("ignored select changed host bit");
    chk_full_drop: assert property (
        wr_data && buffered_mode_enable && !dre_r && !copy
        |=> $stable(tx_buf_r) && tx_full_r)
        else $error("write with full holding buffer not dropped");
    chk_flag_order: assert property (
        s_copy |-> s_flag_walk)
        else $error("empty and receive flags out of order");
    chk_deselect_abort: assert property (
        is_client && ss_n_s |=> sh.cnt_zero && !sh.done)
        else $error("deselect did not halt shifting");
    chk_irq_level: assert property (
        !buffered_mode_enable && if_r && ien_r[`SPI_B_IE] |-> irq)
        else $error("done interrupt not requested");
    chk_bus_answer: assert property (
        (read || write) && waitrequest |=> !waitrequest)
        else $error("bus access waited more than one cycle");
endmodule

// *** shared/spi_params.svh ***
// constants for the serial peripheral engine: register indices, field
// positions, reset values and serial clock timing
// assumes a 100 MHz core clock and word-addressed register access
`ifndef SPI_PARAMS_SVH
`define SPI_PARAMS_SVH

// register indices; byte address is four times the index
`define SPI_IDX_CTL1 3'h0
`define SPI_IDX_CTL2 3'h1
`define SPI_IDX_IEN 3'h2
`define SPI_IDX_FLAG 3'h3
`define SPI_IDX_DATA 3'h4

// control_one fields
`define SPI_B_ENABLE 0
`define SPI_B_HOST 5
`define SPI_CTL1_MASK 8'h21
// control_two fields
`define SPI_B_BUFFERED_MODE_ENABLE 7
`define SPI_B_WAITRX 6
`define SPI_B_SSOUT 3
`define SPI_B_SSIGN 2
`define SPI_CTL2_MASK 8'hCC
// irq_enable_reg fields
`define SPI_B_RXCIE 7
`define SPI_B_ALL_SENT_IRQ_ENABLE 6
`define SPI_B_DREIE 5
`define SPI_B_IE 0
`define SPI_IEN_MASK 8'hE1
// irq_flag_reg fields, normal and buffered layouts
`define SPI_B_IF 7
`define SPI_B_WRITE_COLLISION_FLAG 6
`define SPI_B_RXC 7
`define SPI_B_TXC 6
`define SPI_B_DRE 5
`define SPI_B_OVF 0

`define SPI_RST_CTL 8'h00
`define SPI_RST_BYTE 8'h00

// host serial clock: half period in ns, then in core cycles
`define SPI_CLK_PERIOD_NS 10
`define SPI_SCK_HALF_NS 40
`define SPI_SCK_HALF_CYC (`SPI_SCK_HALF_NS / `SPI_CLK_PERIOD_NS)

`endif

// *** shared/spi_pkg.sv ***
// types shared by the serial peripheral engine and its helpers
// assumes nothing beyond the tool's package support
package spi_pkg;
    typedef logic [31:0] word_t;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW = 2'b01,
        ST_HIGH = 2'b10
    } host_st_e;
endpackage

// *** shared/spi_shift_if.sv ***
// link between the engine control and its byte shift register
// assumes both ends run on the same core clock
`timescale 1ns/100ps
interface spi_shift_if;
    logic load;
    spi_pkg::byte_t load_data;
    logic sample;
    logic shift;
    logic abort;
    logic in_bit;
    logic out_bit;
    logic done;
    spi_pkg::byte_t rx_byte;
    logic cnt_zero;
    logic cnt_last;

    modport ctl (output load, load_data, sample, shift, abort, in_bit,
                 input out_bit, done, rx_byte, cnt_zero, cnt_last);
    modport shifter (input load, load_data, sample, shift, abort, in_bit,
                     output out_bit, done, rx_byte, cnt_zero, cnt_last);
endinterface

// *** logic/spi_sync.sv ***
// two-stage synchroniser for the four serial pins
// assumes the pins are asynchronous to clk
`timescale 1ns/100ps
module spi_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] d,
    output logic [3:0] q
);
    logic [3:0] meta_r;

    // reset level for all pins is high so select reads as released
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 4'hF;
            q <= 4'hF;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// *** logic/spi_shifter.sv ***
// eight-bit shift register with bit counter, msb first
// assumes sample and shift strobes come one cycle wide from the engine
`timescale 1ns/100ps
`include "spi_params.svh"
module spi_shifter (
    input wire logic clk,
    input wire logic rst_n,
    spi_shift_if.shifter port
);
    import spi_pkg::*;

    byte_t sr_r;
    logic [2:0] cnt_r;
    logic bit_r;
    logic done_r;
    wire step = port.shift & ~port.abort;

    assign port.out_bit = sr_r[7];
    assign port.rx_byte = sr_r;
    assign port.done = done_r;
    assign port.cnt_zero = (cnt_r == 3'h0);
    assign port.cnt_last = (cnt_r == 3'h7);

    // a load may land while deselected; abort clears the count and blocks shifts, not the data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sr_r <= `SPI_RST_BYTE;
            cnt_r <= 3'h0;
            bit_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            if (port.load)
                sr_r <= port.load_data;
            else if (step)
                sr_r <= {sr_r[6:0], bit_r};
            if (port.abort)
                cnt_r <= 3'h0;
            else if (port.shift)
                cnt_r <= cnt_r + 3'h1;
            if (port.sample)
                bit_r <= port.in_bit;
            done_r <= step & (cnt_r == 3'h7);
        end
    end
endmodule

// *** test/spi_far_end.sv ***
// far-side model: an outside client when the engine is host, an
// outside host when the engine is client
// assumes the bench resolves sck, mosi and miso from the engine's output enables
`timescale 1ns/100ps
module spi_far_end (
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    output logic sck_drv,
    output logic mosi_drv,
    output logic miso_drv,
    output logic ss_n_drv
);
    import spi_pkg::*;
    logic [15:0] c_tx;
    logic [15:0] c_got;
    assign miso_drv = c_tx[15];
    initial begin
        sck_drv = 1'b0;
        mosi_drv = 1'b0;
        ss_n_drv = 1'b1;
        c_tx = 16'h0000;
        c_got = 16'h0000;
    end
    // client role: take data on the rising edge, change on the falling
    always @(posedge sck) begin
        c_got <= {c_got[14:0], mosi};
    end
    // past the loaded bits the line toggles, so stale data never matches
    always @(negedge sck) begin
        c_tx <= {c_tx[14:0], ~c_tx[0]};
    end
    task automatic load(input logic [15:0] v);
        c_tx = v;
    endtask
    task automatic set_ss(input logic v);
        ss_n_drv <= v;
    endtask
    // host role: the clock rests low between frames
    task automatic xfer(input byte_t tx, input int n, output byte_t rx);
        rx = 8'h00;
        ss_n_drv <= 1'b0;
        for (int i = 0; i < n; i++) begin
            mosi_drv <= tx[7-i];
            #80 sck_drv <= 1'b1;
            rx = {rx[6:0], miso};
            #80 sck_drv <= 1'b0;
        end
        #80 mosi_drv <= ~mosi_drv;
        ss_n_drv <= 1'b1;
    endtask
endmodule

// *** test/tb.sv ***
// self-checking bench: register calls over the wait-stated bus, with
// the far-side model on the serial pins
// assumes the engine answers each access with one wait cycle or more
`timescale 1ns/100ps
`include "spi_params.svh"
module tb;
    import spi_pkg::*;
    logic clk, rst_n, read, write, waitrequest, irq;
    logic [2:0] address;
    word_t writedata, readdata;
    logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
    logic sck_drv, mosi_drv, miso_drv, ss_n_drv;
    wire logic sck_w, mosi_w, miso_w;
    int miscompares, n_checks;
    byte_t rx;
    initial clk = 1'b0;
    always #5 clk = ~clk;
    assign sck_w = sck_oe ? sck_out : sck_drv;
    assign mosi_w = mosi_oe ? mosi_out : mosi_drv;
    assign miso_w = miso_oe ? miso_out : miso_drv;
    spi_engine spi_engine_inst (.clk(clk), .rst_n(rst_n),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .sck_in(sck_w), .sck_out(sck_out),
        .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out),
        .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
        .miso_oe(miso_oe), .ss_n_in(ss_n_drv), .irq(irq));
    spi_far_end spi_far_end_inst (.sck(sck_w), .mosi(mosi_w),
        .miso(miso_w), .sck_drv(sck_drv), .mosi_drv(mosi_drv),
        .miso_drv(miso_drv), .ss_n_drv(ss_n_drv));

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input byte_t e, input byte_t g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [2:0] a, input byte_t d,
                       output byte_t q);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        read <= ~wr;
        write <= wr;
        writedata <= {24'h000000, d};
        @(negedge clk);
        while (waitrequest !== 1'b0 && n < 50) begin
            @(negedge clk);
            n++;
        end
        if (n >= 50) begin
            miscompares++;
            $display("[FAIL] bus answer exp 0 got %b", waitrequest);
        end
        @(posedge clk);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [2:0] a, input byte_t d);
        byte_t t;
        bus(1'b1, a, d, t);
    endtask
    task automatic rdchk(input logic [2:0] a, input byte_t e,
                         input string nm);
        byte_t t;
        bus(1'b0, a, 8'h00, t);
        chk(nm, e, t);
    endtask
    task automatic wait_flag(input int b);
        byte_t t;
        int n;
        t = 8'h00;
        n = 0;
        while (t[b] !== 1'b1 && n < 200) begin
            bus(1'b0, `SPI_IDX_FLAG, 8'h00, t);
            n++;
        end
        chk("flag wait", 8'h01, {7'h00, t[b]});
    endtask
    task automatic frame(input byte_t tx, input int n);
        spi_far_end_inst.xfer(tx, n, rx);
        repeat (6) @(posedge clk);
    endtask
    task automatic irqchk(input logic e);
        @(negedge clk);
        chk("irq", {7'h00, e}, {7'h00, irq});
    endtask

    initial begin
        #200000;
        $display("[FAIL] run length exp done got timeout");
        miscompares++;
        test_done;
    end

    initial begin
        rst_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 3'h0;
        writedata = 32'h00000000;
        miscompares = 0;
        n_checks = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(`SPI_IDX_CTL1, 8'h00, "control_one reset");
        wr(3'h5, 8'hFF);
        rdchk(3'h5, 8'h00, "unmapped");
        // host, normal mode, select ignored
        wr(`SPI_IDX_CTL2, 8'h04);
        wr(`SPI_IDX_IEN, 8'h01);
        wr(`SPI_IDX_CTL1, 8'h21);
        spi_far_end_inst.load(16'h3C81);
        wr(`SPI_IDX_DATA, 8'hA5);
        wr(`SPI_IDX_DATA, 8'h11);
        wait_flag(7);
        irqchk(1'b1);
        rdchk(`SPI_IDX_FLAG, 8'hC0, "done and collision");
        chk("host sent", 8'hA5, spi_far_end_inst.c_got[7:0]);
        wr(`SPI_IDX_FLAG, 8'hC0);
        irqchk(1'b0);
        wr(`SPI_IDX_DATA, 8'h5E);
        wait_flag(7);
        rdchk(`SPI_IDX_DATA, 8'h81, "rx overwritten");
        chk("host sent 2", 8'h5E, spi_far_end_inst.c_got[7:0]);
        // select pin ignored, then honoured
        for (int i = 0; i < 2; i++) begin
            wr(`SPI_IDX_CTL2, i == 0 ? 8'h04 : 8'h08);
            spi_far_end_inst.set_ss(1'b0);
            repeat (6) @(posedge clk);
            rdchk(`SPI_IDX_CTL1, 8'h21, "host kept");
            spi_far_end_inst.set_ss(1'b1);
            repeat (6) @(posedge clk);
        end
        wr(`SPI_IDX_FLAG, 8'hFF);
        wr(`SPI_IDX_CTL2, 8'h00);
        spi_far_end_inst.set_ss(1'b0);
        repeat (6) @(posedge clk);
        rdchk(`SPI_IDX_CTL1, 8'h01, "host lost");
        rdchk(`SPI_IDX_FLAG, 8'h80, "loss flag");
        spi_far_end_inst.set_ss(1'b1);
        repeat (6) @(posedge clk);
        wr(`SPI_IDX_CTL1, 8'h21);
        rdchk(`SPI_IDX_CTL1, 8'h21, "host again");
        // host, buffered; the wait bit must change nothing
        wr(`SPI_IDX_CTL2, 8'hC4);
        wr(`SPI_IDX_FLAG, 8'hFF);
        wr(`SPI_IDX_IEN, 8'h40);
        rdchk(`SPI_IDX_FLAG, 8'h20, "empty after enable");
        spi_far_end_inst.load(16'hABCD);
        wr(`SPI_IDX_DATA, 8'h71);
        wr(`SPI_IDX_DATA, 8'h72);
        wr(`SPI_IDX_DATA, 8'h73);
        wait_flag(6);
        irqchk(1'b1);
        rdchk(`SPI_IDX_FLAG, 8'hE0, "all sent");
        chk("first out", 8'h71, spi_far_end_inst.c_got[15:8]);
        chk("second out", 8'h72, spi_far_end_inst.c_got[7:0]);
        rdchk(`SPI_IDX_DATA, 8'hAB, "fifo head");
        rdchk(`SPI_IDX_DATA, 8'hCD, "fifo next");
        rdchk(`SPI_IDX_DATA, 8'h00, "fifo empty");
        // client, normal mode
        wr(`SPI_IDX_CTL1, 8'h01);
        wr(`SPI_IDX_CTL2, 8'h00);
        wr(`SPI_IDX_IEN, 8'h00);
        wr(`SPI_IDX_FLAG, 8'hFF);
        wr(`SPI_IDX_DATA, 8'h5A);
        frame(8'hC3, 8);
        chk("client out", 8'h5A, rx);
        rdchk(`SPI_IDX_FLAG, 8'h80, "client done");
        rdchk(`SPI_IDX_DATA, 8'hC3, "client in");
        wr(`SPI_IDX_FLAG, 8'hFF);
        wr(`SPI_IDX_DATA, 8'h3E);
        fork
            frame(8'h96, 8);
            begin
                repeat (40) @(posedge clk);
                wr(`SPI_IDX_DATA, 8'h11);
            end
        join
        chk("busy write dropped", 8'h3E, rx);
        rdchk(`SPI_IDX_FLAG, 8'hC0, "client collision");
        wr(`SPI_IDX_FLAG, 8'hFF);
        wr(`SPI_IDX_DATA, 8'h2B);
        frame(8'hF0, 4);
        rdchk(`SPI_IDX_FLAG, 8'h00, "partial no done");
        frame(8'h69, 8);
        rdchk(`SPI_IDX_DATA, 8'h69, "realigned byte");
        // client, buffered, dummy byte first
        wr(`SPI_IDX_CTL2, 8'h80);
        wr(`SPI_IDX_FLAG, 8'hFF);
        wr(`SPI_IDX_DATA, 8'h43);
        rdchk(`SPI_IDX_FLAG, 8'h00, "empty cleared");
        wr(`SPI_IDX_DATA, 8'h45);
        frame(8'hA1, 8);
        chk("dummy byte", 8'h69, rx);
        wr(`SPI_IDX_DATA, 8'h44);
        frame(8'hA2, 8);
        chk("after dummy", 8'h43, rx);
        frame(8'hA3, 8);
        chk("full write dropped", 8'h44, rx);
        rdchk(`SPI_IDX_FLAG, 8'hE1, "buffered flags");
        rdchk(`SPI_IDX_DATA, 8'hA1, "fifo first");
        rdchk(`SPI_IDX_DATA, 8'hA2, "fifo second");
        // client, buffered, no dummy byte
        wr(`SPI_IDX_CTL2, 8'hC0);
        wr(`SPI_IDX_FLAG, 8'hFF);
        wr(`SPI_IDX_DATA, 8'h61);
        frame(8'hB7, 8);
        chk("no dummy", 8'h61, rx);
        test_done;
    end
endmodule
